/* verilog/addr_space_decoder.sv */
// link request address decoder with local target, requester and beat order
// assumes link headers and beats arrive on mclk from same-clock link logic
`timescale 1ns/1ps
// Function
// - special regions found from upper address bits
// - io and config decoded from fixed ranges
// - memory below and above special window
// - interrupt spaces never claimed, forwarded when is_tunnel
// - interrupts carry f8 in bits 31:24
// - multi-doubleword config access target aborted
// - extended config nonposted hits config registers
// - extended config posted write is message
// - low 256 bytes shared by both regions
// - claimed window aligned to 64 bytes
// - reserved not claimed, forwarded or end-of-chain
// - one outstanding nonposted request at most
// - one response buffer per outstanding request
// - respond only after effects globally visible
// - data beats executed in transmitted order
// - config read returns latest written data
module addr_space_decoder (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      req_valid,
  input  wire addr_space_pkg::req_hdr_t  req,
  output addr_space_pkg::verdict_t       verdict,
  output logic                           verdict_valid,
  output logic                           req_ready,
  input  wire logic [63:0]               win_base,
  input  wire logic [63:0]               win_limit,
  input  wire logic [7:0]                bus_num,
  input  wire logic [4:0]                dev_num,
  input  wire logic                      is_tunnel,
  output logic                           fwd_valid,
  output addr_space_pkg::req_hdr_t       fwd_hdr,
  output logic                           msg_valid,
  output logic                           tgt_valid,
  output logic [63:0]                    tgt_addr,
  output logic                           tgt_write,
  input  wire logic                      tgt_done,
  input  wire logic [31:0]               tgt_rdata,
  input  wire logic                      beat_valid,
  input  wire logic [31:0]               beat_data,
  output logic                           exec_valid,
  output logic [63:0]                    exec_addr,
  output logic [31:0]                    exec_data,
  output logic                           rsp_valid,
  output logic                           rsp_abort,
  output logic [31:0]                    rsp_data,
  input  wire logic                      loc_req_valid,
  input  wire addr_space_pkg::req_hdr_t  loc_req,
  input  wire logic                      loc_intr_valid,
  input  wire logic [23:0]               loc_intr_vec,
  output logic                           loc_req_ready,
  output logic                           lnk_req_valid,
  output addr_space_pkg::req_hdr_t       lnk_req,
  input  wire logic                      lnk_rsp_valid,
  input  wire logic [31:0]               lnk_rsp_data,
  output logic                           loc_rsp_valid,
  output logic [31:0]                    loc_rsp_data
);
  import addr_space_pkg::*;

  // ----------------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------------
  function automatic region_t region_of(input logic [63:0] a);
    region_t r;
    if (a < BASE_INTR || a >= BASE_MEM_HI) r = RG_MEM;
    else if (a < BASE_IACK)   r = RG_INTR;
    else if (a < BASE_SMGT)   r = RG_IACK;
    else if (a < BASE_RSVD_A) r = RG_SMGT;
    else if (a < BASE_IO)     r = RG_RSVD;
    else if (a < BASE_CFG)    r = RG_IO;
    else if (a < BASE_XCFG)   r = RG_CFG;
    else if (a < BASE_RSVD_B) r = RG_XCFG;
    else                      r = RG_RSVD;
    return r;
  endfunction

  rsp_state_t state_q, state_d;
  verdict_t   verdict_q;
  logic       verdict_valid_q;
  logic       req_ready_q;
  logic       fwd_valid_q, msg_valid_q;
  req_hdr_t   fwd_hdr_q;
  logic       tgt_valid_q, tgt_write_q;
  logic [63:0] tgt_addr_q;
  logic       cfg_op_q, rsp_abort_q, rsp_valid_q;
  logic [31:0] rsp_data_q;
  logic [3:0] beat_left_q;
  logic [63:0] beat_addr_q;
  logic       exec_valid_q;
  logic [63:0] exec_addr_q;
  logic [31:0] exec_data_q;
  logic       outst_q, lnk_req_valid_q, loc_rsp_valid_q;
  req_hdr_t   lnk_req_q;
  logic [31:0] loc_rsp_data_q;
  logic [31:0] cfg_rdata;

  wire        acc      = req_valid && req_ready_q;
  wire region_t rg     = region_of(req.addr);
  wire        wr_np    = req.write && !req.posted;
  wire        wr_p     = req.write && (req.posted || req.bcast);
  wire        is_io_cfg = (rg == RG_IO) || (rg == RG_CFG);
  wire        is_int_sm = (rg == RG_INTR) || (rg == RG_SMGT);
  wire        multi_dw  = req.dw_cnt > ONE_DW;

  // requests the far side must never send; flagged, never executed here
  wire ill_iocfg = is_io_cfg && wr_p;
  wire ill_intsm = is_int_sm && wr_np;
  wire ill_iack  = (rg == RG_IACK) && (req.write || req.bcast || req.upstream);
  wire illegal_now = ill_iocfg || ill_intsm || ill_iack;

  // ----------------------------------------------------------------------
  // local claim
  // ----------------------------------------------------------------------
  // low bits dropped so the claimed window always starts on 64 bytes
  wire [63:0] win_lo = {win_base[63:WIN_ALIGN_W], {WIN_ALIGN_W{1'b0}}};
  wire [63:0] win_hi = {win_limit[63:WIN_ALIGN_W], {WIN_ALIGN_W{1'b1}}};
  wire mem_hit = (rg == RG_MEM) && req.addr >= win_lo && req.addr <= win_hi;

  wire [7:0] cfg_bus  = req.addr[CFG_BUS_LSB +: 8];
  wire [4:0] cfg_dev  = req.addr[CFG_DEV_LSB +: 5];
  wire [7:0] xcfg_bus = req.addr[XCFG_BUS_LSB +: 8];
  wire [4:0] xcfg_dev = req.addr[XCFG_DEV_LSB +: 5];
  wire cfg_hit  = (rg == RG_CFG) && !req.addr[CFG_TYPE_BIT] && cfg_dev == dev_num;
  // only the low 256 bytes exist here, reached alike from both regions
  wire xcfg_low = req.addr[11:8] == XCFG_HI_ZERO;
  wire xcfg_me  = (rg == RG_XCFG) && xcfg_bus == bus_num && xcfg_dev == dev_num;
  wire xcfg_reg = xcfg_me && !req.posted && xcfg_low;
  wire devmsg_now = (rg == RG_XCFG) && req.write && req.posted;
  wire msg_type1  = xcfg_bus != bus_num;
  wire msg_local  = devmsg_now && !msg_type1 && xcfg_dev == dev_num;
  wire cfg_claim  = (cfg_hit || xcfg_reg) && !illegal_now;
  // multi-dword config access is aborted rather than split
  wire abort_now  = cfg_claim && multi_dw;
  wire claim_now  = (mem_hit || cfg_claim || msg_local) && !illegal_now;
  // interrupt, iack and system-management space is never claimed
  wire fwd_now    = !claim_now && is_tunnel;
  wire eoc_np     = !claim_now && !is_tunnel && !req.posted;
  wire [CFG_IDX_W-1:0] cfg_idx = req.addr[CFG_IDX_LSB +: CFG_IDX_W];
  wire cfg_wr  = acc && cfg_claim && !abort_now && req.write;
  wire np_loc  = acc && !req.posted && (claim_now || eoc_np || illegal_now);
  wire mem_op  = acc && mem_hit && !illegal_now;

  verdict_t verdict_now;
  assign verdict_now.region    = rg;
  assign verdict_now.illegal   = illegal_now;
  assign verdict_now.abort     = abort_now;
  assign verdict_now.claim     = claim_now;
  assign verdict_now.forward   = fwd_now;
  assign verdict_now.devmsg    = devmsg_now;
  assign verdict_now.msg_type1 = msg_type1;

  cfg_reg_mem u_cfg (
    .mclk    (mclk),
    .wr_en   (cfg_wr),
    .wr_idx  (cfg_idx),
    .wr_data (req.data),
    .rd_idx  (cfg_idx),
    .rd_data (cfg_rdata)
  );

  // ----------------------------------------------------------------------
  // response sequencer
  // ----------------------------------------------------------------------
  // only one local nonposted is in flight, so one response slot suffices
  wire direct_rsp = abort_now || illegal_now || eoc_np;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (np_loc) begin
          state_d = direct_rsp ? ST_RESP : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cfg_op_q || tgt_done) begin
          state_d = ST_RESP;
        end
      end
      ST_RESP: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  wire take_rsp = state_q == ST_WAIT && state_d == ST_RESP;
  wire [31:0] rsp_data_d = cfg_op_q ? cfg_rdata : tgt_rdata;

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q     <= ST_IDLE;
      req_ready_q <= 1'b0;
      cfg_op_q    <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_abort_q <= 1'b0;
      rsp_data_q  <= DATA_RST;
    end else begin
      state_q     <= state_d;
      req_ready_q <= state_d == ST_IDLE && !np_loc;
      cfg_op_q    <= np_loc ? cfg_claim : cfg_op_q;
      rsp_valid_q <= state_d == ST_RESP;
      rsp_abort_q <= np_loc ? direct_rsp : (take_rsp ? 1'b0 : rsp_abort_q);
      rsp_data_q  <= take_rsp ? rsp_data_d : (np_loc ? DATA_RST : rsp_data_q);
    end
  end

  // ----------------------------------------------------------------------
  // verdict, forward and local target strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      verdict_q       <= '0;
      verdict_valid_q <= 1'b0;
      fwd_valid_q     <= 1'b0;
      fwd_hdr_q       <= '0;
      msg_valid_q     <= 1'b0;
      tgt_valid_q     <= 1'b0;
      tgt_write_q     <= 1'b0;
      tgt_addr_q      <= ADDR_RST;
    end else begin
      verdict_q       <= acc ? verdict_now : verdict_q;
      verdict_valid_q <= acc;
      fwd_valid_q     <= acc && fwd_now;
      fwd_hdr_q       <= acc ? req : fwd_hdr_q;
      msg_valid_q     <= acc && msg_local && !illegal_now;
      tgt_valid_q     <= mem_op;
      tgt_write_q     <= mem_op ? req.write : tgt_write_q;
      tgt_addr_q      <= mem_op ? req.addr : tgt_addr_q;
    end
  end

  // ----------------------------------------------------------------------
  // write beats
  // ----------------------------------------------------------------------
  // a single register stage keeps beats in arrival order; no reordering
  wire beat_take = beat_valid && beat_left_q != 4'h0;
  always_ff @(posedge mclk) begin
    if (srst) begin
      beat_left_q  <= 4'h0;
      beat_addr_q  <= ADDR_RST;
      exec_valid_q <= 1'b0;
      exec_addr_q  <= ADDR_RST;
      exec_data_q  <= DATA_RST;
    end else begin
      if (mem_op && req.write) begin
        beat_left_q <= req.dw_cnt;
        beat_addr_q <= req.addr;
      end else if (beat_take) begin
        beat_left_q <= beat_left_q - 4'h1;
        beat_addr_q <= beat_addr_q + BEAT_STEP;
      end
      exec_valid_q <= beat_take;
      exec_addr_q  <= beat_take ? beat_addr_q : exec_addr_q;
      exec_data_q  <= beat_take ? beat_data : exec_data_q;
    end
  end

  // ----------------------------------------------------------------------
  // local requester
  // ----------------------------------------------------------------------
  req_hdr_t intr_hdr;
  always_comb begin
    intr_hdr        = '0;
    intr_hdr.addr   = BASE_INTR;
    intr_hdr.addr[INTR_TAG_LSB +: 8] = INTR_TAG;
    intr_hdr.addr[23:0] = loc_intr_vec;
    intr_hdr.write  = 1'b1;
    intr_hdr.posted = 1'b1;
    intr_hdr.dw_cnt = ONE_DW;
  end

  wire issue_intr = loc_intr_valid && loc_req_ready;
  wire issue_req  = loc_req_valid && loc_req_ready && !loc_intr_valid;
  wire issue_np   = issue_req && !loc_req.posted;

  always_ff @(posedge mclk) begin
    if (srst) begin
      outst_q         <= 1'b0;
      lnk_req_valid_q <= 1'b0;
      lnk_req_q       <= '0;
      loc_rsp_valid_q <= 1'b0;
      loc_rsp_data_q  <= DATA_RST;
    end else begin
      outst_q         <= issue_np || (outst_q && !lnk_rsp_valid);
      lnk_req_valid_q <= issue_intr || issue_req;
      lnk_req_q       <= issue_intr ? intr_hdr : (issue_req ? loc_req : lnk_req_q);
      loc_rsp_valid_q <= lnk_rsp_valid && outst_q;
      loc_rsp_data_q  <= (lnk_rsp_valid && outst_q) ? lnk_rsp_data : loc_rsp_data_q;
    end
  end

  // ready held low the cycle after issue, and for a nonposted request until the response comes back
  assign loc_req_ready = !outst_q && !lnk_req_valid_q;

  assign verdict       = verdict_q;
  assign verdict_valid = verdict_valid_q;
  assign req_ready     = req_ready_q;
  assign fwd_valid     = fwd_valid_q;
  assign fwd_hdr       = fwd_hdr_q;
  assign msg_valid     = msg_valid_q;
  assign tgt_valid     = tgt_valid_q;
  assign tgt_addr      = tgt_addr_q;
  assign tgt_write     = tgt_write_q;
  assign exec_valid    = exec_valid_q;
  assign exec_addr     = exec_addr_q;
  assign exec_data     = exec_data_q;
  assign rsp_valid     = rsp_valid_q;
  assign rsp_abort     = rsp_abort_q;
  assign rsp_data      = rsp_data_q;
  assign lnk_req_valid = lnk_req_valid_q;
  assign lnk_req       = lnk_req_q;
  assign loc_rsp_valid = loc_rsp_valid_q;
  assign loc_rsp_data  = loc_rsp_data_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  ill_flag_next_a: assert property (acc && illegal_now |=> verdict_valid_q && verdict_q.illegal)
    else $error("illegal request not flagged on next edge");
  intr_no_claim_a: assert property (verdict_valid_q && verdict_q.region inside {RG_INTR, RG_IACK, RG_SMGT}
    |-> !verdict_q.claim)
    else $error("interrupt space claimed locally");
  rsvd_no_claim_a: assert property (verdict_valid_q && verdict_q.region == RG_RSVD
    |-> !verdict_q.claim && verdict_q.forward == $past(is_tunnel))
    else $error("reserved space claimed or misrouted");
  rsp_after_vis_a: assert property (state_q == ST_WAIT && !cfg_op_q && !tgt_done |=> !rsp_valid_q)
    else $error("response before target done");
  cfg_abort_a: assert property (acc && abort_now && !req.posted |=> rsp_valid_q && rsp_abort_q)
    else $error("multi-dword config access not aborted");
  intr_tag_a: assert property (issue_intr |=> lnk_req_valid_q && lnk_req_q.addr[31:24] == INTR_TAG
    && lnk_req_q.posted)
    else $error("interrupt issued without f8 tag");
  one_outst_a: assert property (issue_np || (outst_q && !lnk_rsp_valid) |=> !loc_req_ready)
    else $error("second nonposted issued while one outstanding");
  beat_order_a: assert property (exec_valid_q ##1 exec_valid_q |-> exec_addr_q == $past(exec_addr_q) + BEAT_STEP)
    else $error("data beat out of order");
  win_align_a: assert property (tgt_valid_q |-> tgt_addr_q >= win_lo)
    else $error("access below aligned window base");

  cfg_rd_c: cover property (acc && cfg_claim && !req.write && !req.posted ##[1:4] rsp_valid_q);
  fwd_c:    cover property (fwd_valid_q && fwd_hdr_q.addr >= BASE_INTR && fwd_hdr_q.addr < BASE_IACK);
  np_rt_c:  cover property (issue_np ##[1:20] loc_rsp_valid_q);

endmodule

/* verilog/addr_space_pkg.sv */
// address map, request header and verdict types for the link address decoder
// assumes a single core clock; addresses are carried at full 64-bit width
package addr_space_pkg;

  // ----------------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------------
  localparam logic [63:0] BASE_INTR   = 64'h0000_00FD_0000_0000;
  localparam logic [63:0] BASE_IACK   = 64'h0000_00FD_F900_0000;
  localparam logic [63:0] BASE_SMGT   = 64'h0000_00FD_F910_0000;
  localparam logic [63:0] BASE_RSVD_A = 64'h0000_00FD_F920_0000;
  localparam logic [63:0] BASE_IO     = 64'h0000_00FD_FC00_0000;
  localparam logic [63:0] BASE_CFG    = 64'h0000_00FD_FE00_0000;
  localparam logic [63:0] BASE_XCFG   = 64'h0000_00FE_0000_0000;
  localparam logic [63:0] BASE_RSVD_B = 64'h0000_00FE_2000_0000;
  localparam logic [63:0] BASE_MEM_HI = 64'h0000_0100_0000_0000;

  // ----------------------------------------------------------------------
  // field positions and constants
  // ----------------------------------------------------------------------
  localparam logic [7:0]  INTR_TAG     = 8'hF8;
  localparam int          INTR_TAG_LSB = 24;
  localparam int          WIN_ALIGN_W  = 6;
  localparam int          CFG_IDX_W    = 6;
  localparam int          CFG_IDX_LSB  = 2;
  localparam int          CFG_TYPE_BIT = 24;
  localparam int          CFG_BUS_LSB  = 16;
  localparam int          CFG_DEV_LSB  = 11;
  localparam int          XCFG_BUS_LSB = 20;
  localparam int          XCFG_DEV_LSB = 15;
  localparam logic [3:0]  XCFG_HI_ZERO = 4'h0;
  localparam logic [63:0] BEAT_STEP    = 64'h0000_0000_0000_0004;
  localparam logic [3:0]  ONE_DW       = 4'h1;
  localparam logic [31:0] DATA_RST     = 32'h0000_0000;
  localparam logic [63:0] ADDR_RST     = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    RG_MEM  = 4'h0,
    RG_INTR = 4'h1,
    RG_IACK = 4'h2,
    RG_SMGT = 4'h3,
    RG_RSVD = 4'h4,
    RG_IO   = 4'h5,
    RG_CFG  = 4'h6,
    RG_XCFG = 4'h7
  } region_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESP = 3'b100
  } rsp_state_t;

  typedef struct packed {
    logic [63:0] addr;
    logic        write;
    logic        posted;
    logic        bcast;
    logic        upstream;
    logic [3:0]  dw_cnt;
    logic [3:0]  seqid;
    logic [31:0] data;
  } req_hdr_t;

  typedef struct packed {
    region_t region;
    logic    illegal;
    logic    abort;
    logic    claim;
    logic    forward;
    logic    devmsg;
    logic    msg_type1;
  } verdict_t;

endpackage

/* verilog/cfg_reg_mem.sv */
// configuration register store, one word per index, registered read port
// assumes one write and one read per clock from the decoder
`timescale 1ns/1ps
module cfg_reg_mem (
  input  wire logic                                  mclk,
  input  wire logic                                  wr_en,
  input  wire logic [addr_space_pkg::CFG_IDX_W-1:0]  wr_idx,
  input  wire logic [31:0]                           wr_data,
  input  wire logic [addr_space_pkg::CFG_IDX_W-1:0]  rd_idx,
  output logic      [31:0]                           rd_data
);
  import addr_space_pkg::*;

  logic [31:0] mem [2**CFG_IDX_W];

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // a read of the word being written returns the new value
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= (wr_en && wr_idx == rd_idx) ? wr_data : mem[rd_idx];
  end

endmodule

/* verification/link_partner.sv */
// far-side model: local memory target and link neighbour of the decoder
// assumes the decoder's same-clock target and link request ports
`timescale 1ns/1ps
module link_partner #(
  parameter logic [31:0] MEM_RDATA = 32'h5A5A_A5A5
) (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      tgt_valid,
  input  wire logic                      lnk_req_valid,
  input  wire addr_space_pkg::req_hdr_t  lnk_req,
  output logic                           tgt_done,
  output logic [31:0]                    tgt_rdata,
  output logic                           lnk_rsp_valid,
  output logic [31:0]                    lnk_rsp_data
);
  import addr_space_pkg::*;
  logic [1:0] tgt_q;
  logic [2:0] lnk_q;
  // ----------------------------------------------------------------------
  // delayed completions
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      tgt_q <= 2'h0;
      lnk_q <= 3'h0;
    end else begin
      tgt_q <= {tgt_q[0], tgt_valid};
      lnk_q <= {lnk_q[1:0], lnk_req_valid && !lnk_req.posted};
    end
  end
  assign tgt_done      = tgt_q[1];
  // stale data is inverted so a late sample can never match
  assign tgt_rdata     = tgt_done ? MEM_RDATA : ~MEM_RDATA;
  assign lnk_rsp_valid = lnk_q[2];
  assign lnk_rsp_data  = lnk_rsp_valid ? MEM_RDATA : ~MEM_RDATA;
endmodule

/* verification/tb_addr_space_decoder.sv */
// self-checking bench for the link address decoder
// assumes link_partner on the target and link ports, 200 MHz mclk
`timescale 1ns/1ps
module tb_addr_space_decoder;
  import addr_space_pkg::*;
  localparam logic [31:0] RD = 32'h5A5A_A5A5;
  logic mclk = 1'b0, srst = 1'b1, req_valid = 1'b0, loc_intr_valid = 1'b0;
  req_hdr_t req = '0, fwd_hdr, lnk_req;
  verdict_t verdict;
  logic [23:0] loc_intr_vec = 24'h0, iv;
  logic verdict_valid, req_ready, fwd_valid, msg_valid, tgt_valid, tgt_write, tgt_done, exec_valid;
  logic rsp_valid, rsp_abort, loc_req_ready, lnk_req_valid, lnk_rsp_valid, loc_rsp_valid;
  logic [63:0] tgt_addr, exec_addr;
  logic [31:0] tgt_rdata, exec_data, rsp_data, lnk_rsp_data, loc_rsp_data, w;
  logic [34:0] re;
  logic [4:0] vq[$];
  logic [34:0] rq[$];
  logic [63:0] eq[$], fq[$];
  logic is_tunnel = 1'b0, beat_valid = 1'b0, loc_req_valid = 1'b0;
  logic [31:0] beat_data = 32'h0;
  int err_count = 0, n_compared = 0, lnk_n = 0, lr_n = 0, fwd_n = 0, msg_n = 0;
  logic [63:0] base_a [10] = '{64'h1000, BASE_INTR, BASE_IACK, BASE_SMGT, BASE_RSVD_A, BASE_IO, BASE_CFG,
                              BASE_XCFG, BASE_RSVD_B, BASE_MEM_HI};
  region_t rg_a [10] = '{RG_MEM, RG_INTR, RG_IACK, RG_SMGT, RG_RSVD, RG_IO, RG_CFG, RG_XCFG, RG_RSVD, RG_MEM};
  logic [9:0] ab_a = 10'b11_0011_1110;
  always #2.5 mclk = ~mclk;
  addr_space_decoder dut_u (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req(req), .verdict(verdict),
    .verdict_valid(verdict_valid), .req_ready(req_ready), .win_base(64'h1000), .win_limit(64'h1FFF),
    .bus_num(8'h00), .dev_num(5'h00), .is_tunnel(is_tunnel), .fwd_valid(fwd_valid), .fwd_hdr(fwd_hdr),
    .msg_valid(msg_valid), .tgt_valid(tgt_valid), .tgt_addr(tgt_addr), .tgt_write(tgt_write),
    .tgt_done(tgt_done), .tgt_rdata(tgt_rdata), .beat_valid(beat_valid), .beat_data(beat_data),
    .exec_valid(exec_valid), .exec_addr(exec_addr), .exec_data(exec_data), .rsp_valid(rsp_valid),
    .rsp_abort(rsp_abort), .rsp_data(rsp_data), .loc_req_valid(loc_req_valid), .loc_req('0),
    .loc_intr_valid(loc_intr_valid), .loc_intr_vec(loc_intr_vec), .loc_req_ready(loc_req_ready),
    .lnk_req_valid(lnk_req_valid), .lnk_req(lnk_req), .lnk_rsp_valid(lnk_rsp_valid),
    .lnk_rsp_data(lnk_rsp_data), .loc_rsp_valid(loc_rsp_valid), .loc_rsp_data(loc_rsp_data));
  link_partner #(.MEM_RDATA(RD)) far_u (.mclk(mclk), .srst(srst), .tgt_valid(tgt_valid),
    .lnk_req_valid(lnk_req_valid), .lnk_req(lnk_req), .tgt_done(tgt_done), .tgt_rdata(tgt_rdata),
    .lnk_rsp_valid(lnk_rsp_valid), .lnk_rsp_data(lnk_rsp_data));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // f is {write, posted, bcast, upstream}; ck selects {abort, data} checks
  task automatic go(input logic [63:0] a, input logic [3:0] f, input logic [3:0] dw, input logic [31:0] d,
                    input region_t rg, input logic il, input logic [1:0] ck, input logic ab, input logic [31:0] ed);
    req_hdr_t h;
    int i;
    h.addr = a;
    {h.write, h.posted, h.bcast, h.upstream} = f;
    h.dw_cnt = dw;
    h.seqid = 4'h0;
    h.data = d;
    vq.push_back({rg, il});
    if (!f[2]) rq.push_back({ck, ab, ed});
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= h;
    for (i = 0; i < 50; i++) begin
      @(negedge mclk);
      if (req_ready === 1'b1) break;
    end
    if (i == 50) begin
      err_count++;
      wrap_up();
    end
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask
  // ----------------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (verdict_valid === 1'b1 && vq.size() > 0) chk({verdict.region, verdict.illegal}, vq.pop_front());
    if (rsp_valid === 1'b1 && rq.size() > 0) begin
      re = rq.pop_front();
      if (re[34]) chk(rsp_abort, re[32]);
      if (re[33]) chk(rsp_data, re[31:0]);
    end
    if (lnk_req_valid === 1'b1) begin
      lnk_n++;
      if (lnk_req.posted === 1'b1) begin
        chk({lnk_req.addr[63:24], lnk_req.posted}, {BASE_INTR[63:32], INTR_TAG, 1'b1});
        chk(lnk_req.addr[23:0], iv);
      end else chk(lnk_req.addr, 64'h0);
    end
    if (loc_rsp_valid === 1'b1) begin
      lr_n++;
      chk(loc_rsp_data, RD);
    end
    if (tgt_valid === 1'b1) chk(tgt_addr >> 12, 64'h1);
    if (exec_valid === 1'b1 && eq.size() > 0) chk({exec_addr[31:0], exec_data}, eq.pop_front());
    if (fwd_valid === 1'b1) begin
      fwd_n++;
      chk(fwd_hdr.addr, (fq.size() > 0) ? fq.pop_front() : 64'h0);
    end
    if (msg_valid === 1'b1) msg_n++;
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    w = $urandom(73156);
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    // mem data only checked where the window claims the read
    for (int k = 0; k < 10; k++) begin
      go(base_a[k] + ($urandom & 32'hFC), 4'h0, 4'h1, 32'h0, rg_a[k], 1'b0, (k == 0) ? 2'b11 : (k == 5) ? 2'b00 : 2'b10,
         ab_a[k], RD);
    end
    $display("test regions done");
    go(BASE_CFG, 4'hC, 4'h1, 32'h0, RG_CFG, 1'b1, 2'b00, 1'b0, 32'h0);
    go(BASE_IO, 4'hC, 4'h1, 32'h0, RG_IO, 1'b1, 2'b00, 1'b0, 32'h0);
    go(BASE_INTR, 4'h8, 4'h1, 32'h0, RG_INTR, 1'b1, 2'b10, 1'b1, 32'h0);
    go(BASE_SMGT, 4'h8, 4'h1, 32'h0, RG_SMGT, 1'b1, 2'b10, 1'b1, 32'h0);
    go(BASE_IACK, 4'hC, 4'h1, 32'h0, RG_IACK, 1'b1, 2'b00, 1'b0, 32'h0);
    go(BASE_IACK, 4'h1, 4'h1, 32'h0, RG_IACK, 1'b1, 2'b10, 1'b1, 32'h0);
    go(BASE_CFG, 4'h0, 4'h2, 32'h0, RG_CFG, 1'b0, 2'b10, 1'b1, 32'h0);
    $display("test illegal done");
    w = $urandom;
    go(BASE_CFG + 64'h14, 4'h8, 4'h1, w, RG_CFG, 1'b0, 2'b10, 1'b0, 32'h0);
    go(BASE_XCFG + 64'h14, 4'h0, 4'h1, 32'h0, RG_XCFG, 1'b0, 2'b11, 1'b0, w);
    go(BASE_XCFG + 64'h20, 4'hC, 4'h1, w, RG_XCFG, 1'b0, 2'b00, 1'b0, 32'h0);
    $display("test config done");
    // two beats back to back; each must land 4 bytes above the last
    eq.push_back({32'h0000_1040, w});
    eq.push_back({32'h0000_1044, ~w});
    go(64'h1040, 4'hC, 4'h2, 32'h0, RG_MEM, 1'b0, 2'b00, 1'b0, 32'h0);
    beat_valid <= 1'b1;
    beat_data <= w;
    @(posedge mclk);
    beat_data <= ~w;
    @(posedge mclk);
    beat_valid <= 1'b0;
    is_tunnel <= 1'b1;
    fq.push_back(BASE_INTR);
    fq.push_back(BASE_RSVD_B);
    go(BASE_INTR, 4'hC, 4'h1, 32'h0, RG_INTR, 1'b0, 2'b00, 1'b0, 32'h0);
    go(BASE_RSVD_B, 4'hC, 4'h1, 32'h0, RG_RSVD, 1'b0, 2'b00, 1'b0, 32'h0);
    $display("test beats and forward done");
    iv = $urandom;
    @(posedge mclk);
    loc_intr_valid <= 1'b1;
    loc_intr_vec <= iv;
    @(posedge mclk);
    loc_intr_valid <= 1'b0;
    @(posedge mclk);
    loc_req_valid <= 1'b1;
    @(posedge mclk);
    loc_req_valid <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(lnk_n, 2);
    chk({lr_n[7:0], fwd_n[7:0], msg_n[7:0]}, 24'h01_02_01);
    chk(vq.size() + rq.size() + eq.size() + fq.size(), 0);
    $display("test interrupt done");
    wrap_up();
  end
endmodule
